// ===== design/cfm_unit.sv
// Character move and compare sequencer
module cfm_unit (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        issue,
    input  wire cfm_pkg::cfm_op_t            opcode,
    input  wire logic [1:0]                  parcel,
    input  wire logic [cfm_pkg::WORD_W-1:0]  instrWord,
    input  wire logic [cfm_pkg::ADDR_W-1:0]  indexRegJ,
    input  wire logic [cfm_pkg::ADDR_W-1:0]  collateTableBaseReg,
    input  wire logic [cfm_pkg::ADDR_W-1:0]  programRelativeBase,
    input  wire logic [cfm_pkg::ADDR_W-1:0]  programFieldLength,
    input  wire logic                        exchangeReq,
    output logic                             memReq,
    output logic                             memWrite,
    output logic      [cfm_pkg::ADDR_W-1:0]  memAddr,
    output logic      [cfm_pkg::WORD_W-1:0]  memWdata,
    input  wire logic                        memAck,
    input  wire logic [cfm_pkg::WORD_W-1:0]  memRdata,
    output logic                             busy,
    output logic                             done,
    output logic                             illegalInstr,
    output logic                             outOfRange,
    output logic                             interrupted,
    output logic                             skipLowerParcels,
    output logic      [cfm_pkg::WORD_W-1:0]  compareResultReg
);
    localparam int AW = cfm_pkg::ADDR_W;
    localparam int WW = cfm_pkg::WORD_W;
    localparam int CW = cfm_pkg::CHAR_W;
    localparam int LW = cfm_pkg::LEN_W;
    localparam int PW = cfm_pkg::POS_W;

    typedef enum logic [3:0] {
        S_IDLE,
        S_DESC,
        S_LOADA,
        S_LOADB,
        S_STEP,
        S_TBLA,
        S_TBLB,
        S_WRB
    } cfm_state_t;

    cfm_state_t       state_q, state_d;
    cfm_pkg::cfm_op_t op_q, op_d;
    logic [AW-1:0]    addrA_q, addrA_d, addrB_q, addrB_d;
    logic [PW-1:0]    offA_q, offA_d, offB_q, offB_d;
    logic [LW-1:0]    remain_q, remain_d;
    logic [WW-1:0]    wordA_q, wordA_d, wordB_q, wordB_d;
    logic             aValid_q, aValid_d, bValid_q, bValid_d;
    logic             dirty_q, dirty_d, stop_q, stop_d;
    logic [CW-1:0]    colA_q, colA_d;
    logic [WW-1:0]    result_q, result_d;
    logic             done_q, done_d, oor_q, oor_d, ill_q, ill_d;
    logic             intr_q, intr_d, skip_q, skip_d;
    logic             loadNow, doAdvance, decide, greater;

    cfm_mem_if mem ();

    cfm_mem_port u_port (
        .clk         (clk),
        .reset       (reset),
        .relBase     (programRelativeBase),
        .fieldLength (programFieldLength),
        .cmd         (mem.port),
        .memReq      (memReq),
        .memWrite    (memWrite),
        .memAddr     (memAddr),
        .memWdata    (memWdata),
        .memAck      (memAck),
        .memRdata    (memRdata)
    );

    // Character pickers for both fields and the table word
    wire [CW-1:0] chrA, chrB, colVal;
    wire [WW-1:0] mergedB;
    wire [2:0]    tblIdx = (state_q == S_TBLA) ? chrA[2:0] : chrB[2:0]; // RULE18

    cfm_char_lane #(.CHARS(cfm_pkg::CHARS), .CHAR_W(CW)) u_laneA (
        .word    (wordA_q),
        .pos     (offA_q),
        .newChar ('0),
        .chr     (chrA),
        .merged  ()
    );

    cfm_char_lane #(.CHARS(cfm_pkg::CHARS), .CHAR_W(CW)) u_laneB (
        .word    (wordB_q),
        .pos     (offB_q),
        .newChar (chrA),
        .chr     (chrB),
        .merged  (mergedB)
    );

    cfm_char_lane #(.CHARS(cfm_pkg::CHARS), .CHAR_W(CW)) u_laneT (
        .word    (mem.rdata),
        .pos     ({1'b0, tblIdx}),
        .newChar ('0),
        .chr     (colVal),
        .merged  ()
    );

    // Field decode: descriptor while it arrives, else the instruction word
    wire          inDesc = (state_q == S_DESC);
    wire [WW-1:0] fw     = inDesc ? mem.rdata : instrWord;
    wire          indSel = inDesc;
    wire [AW-1:0] fSa    = fw[cfm_pkg::SA_POS +: AW]; // RULE3
    wire [AW-1:0] fDa    = fw[cfm_pkg::DA_POS +: AW];
    wire [PW-1:0] fSo    = fw[cfm_pkg::SO_POS +: PW];
    wire [PW-1:0] fDo    = fw[cfm_pkg::DO_POS +: PW];
    wire [3:0]    fLo    = fw[cfm_pkg::LO_POS +: cfm_pkg::LO_W];
    wire [8:0]    fHi    = fw[cfm_pkg::HI_POS +: cfm_pkg::HI_W];
    // Direct forms only carry three high bits, so 127 is the ceiling
    wire [8:0]    fHiDir = {6'h00, fHi[cfm_pkg::HI_DIR_W-1:0]}; // RULE7
    wire [LW-1:0] fLen   = {indSel ? fHi : fHiDir, fLo}; // RULE6 RULE8
    wire          badOff = (fSo > cfm_pkg::LAST_POS) || (fDo > cfm_pkg::LAST_POS); // RULE4
    wire [AW-1:0] descAddr = indexRegJ + instrWord[cfm_pkg::KJ_POS +: AW]; // RULE12

    // Step conditions
    wire isMove   = (op_q == cfm_pkg::OP_MOVE_IND) || (op_q == cfm_pkg::OP_MOVE_DIR);
    wire collated = (op_q == cfm_pkg::OP_CMP_COL);
    wire lastA    = (offA_q == cfm_pkg::LAST_POS);
    wire lastB    = (offB_q == cfm_pkg::LAST_POS);
    wire endNow   = (remain_q == '0) || stop_q;
    wire canIntr  = exchangeReq && (remain_q > cfm_pkg::INTR_LIMIT); // RULE11
    wire [WW-1:0] countWord = {{(WW-LW){1'b0}}, remain_q}; // RULE16

    // Memory request is a function of the state alone
    assign mem.req = (state_q != S_IDLE) && (state_q != S_STEP);
    assign mem.we  = (state_q == S_WRB);
    assign mem.wdata = wordB_q;
    always_comb begin
        unique case (state_q)
            S_DESC:  mem.addr = addrA_q;
            S_LOADA: mem.addr = addrA_q;
            S_TBLA:  mem.addr = collateTableBaseReg + AW'(chrA[5:3]); // RULE17 RULE18
            S_TBLB:  mem.addr = collateTableBaseReg + AW'(chrB[5:3]); // RULE17 RULE18
            default: mem.addr = addrB_q;
        endcase
    end

    // Sequencer next-state logic
    always_comb begin
        state_d  = state_q;
        op_d     = op_q;
        addrA_d  = addrA_q;
        addrB_d  = addrB_q;
        offA_d   = offA_q;
        offB_d   = offB_q;
        remain_d = remain_q;
        wordA_d  = wordA_q;
        wordB_d  = wordB_q;
        aValid_d = aValid_q;
        bValid_d = bValid_q;
        dirty_d  = dirty_q;
        stop_d   = stop_q;
        colA_d   = colA_q;
        result_d = result_q;
        done_d   = 1'b0;
        oor_d    = 1'b0;
        ill_d    = 1'b0;
        intr_d   = 1'b0;
        skip_d   = 1'b0;
        loadNow  = 1'b0;
        doAdvance = 1'b0;
        decide   = 1'b0;
        greater  = 1'b0;
        unique case (state_q)
            S_IDLE: begin
                if (issue && parcel != cfm_pkg::FIRST_PARCEL) begin
                    ill_d = 1'b1; // RULE1
                end else if (issue) begin
                    op_d = opcode;
                    if (opcode == cfm_pkg::OP_MOVE_IND) begin
                        addrA_d = descAddr; // RULE12
                        state_d = S_DESC;
                    end else begin
                        loadNow = 1'b1;
                    end
                end
            end
            S_DESC: begin
                if (mem.ack) begin
                    loadNow = 1'b1;
                end
            end
            S_LOADA: begin
                if (mem.ack) begin
                    wordA_d  = mem.rdata;
                    aValid_d = 1'b1;
                    state_d  = S_STEP;
                end
            end
            S_LOADB: begin
                if (mem.ack) begin
                    wordB_d  = mem.rdata;
                    bValid_d = 1'b1;
                    state_d  = S_STEP;
                end
            end
            S_STEP: begin
                if (endNow && dirty_q) begin
                    state_d = S_WRB;
                end else if (endNow) begin
                    done_d  = 1'b1;
                    intr_d  = stop_q;
                    state_d = S_IDLE;
                    if (!stop_q && !isMove) begin
                        result_d = cfm_pkg::RESULT_RST; // RULE14
                    end
                    if (!stop_q && op_q == cfm_pkg::OP_MOVE_IND) begin
                        result_d = cfm_pkg::RESULT_RST; // RULE13
                        skip_d   = 1'b1; // RULE13
                    end
                end else if (canIntr) begin
                    stop_d = 1'b1; // RULE11
                end else if (!aValid_q) begin
                    state_d = S_LOADA;
                end else if (!bValid_q) begin
                    state_d = S_LOADB;
                end else if (isMove) begin
                    // Left to right, one character per step
                    wordB_d   = mergedB; // RULE10
                    dirty_d   = 1'b1;
                    doAdvance = 1'b1;
                    if (lastB) begin
                        state_d = S_WRB;
                    end
                end else if (chrA == chrB) begin
                    doAdvance = 1'b1;
                end else if (collated) begin
                    state_d = S_TBLA; // RULE15
                end else begin
                    decide  = 1'b1; // RULE19
                    greater = chrA > chrB;
                end
            end
            S_TBLA: begin
                if (mem.ack) begin
                    colA_d  = colVal;
                    state_d = S_TBLB;
                end
            end
            S_TBLB: begin
                if (mem.ack && colVal == colA_q) begin
                    doAdvance = 1'b1; // RULE15
                    state_d   = S_STEP;
                end else if (mem.ack) begin
                    decide  = 1'b1;
                    greater = colA_q > colVal;
                end
            end
            S_WRB: begin
                // Whole destination word goes back, other characters kept
                if (mem.ack) begin
                    addrB_d  = addrB_q + 1'b1;
                    bValid_d = 1'b0;
                    dirty_d  = 1'b0;
                    state_d  = S_STEP;
                end
            end
        endcase

        // Walk both fields one position
        if (doAdvance) begin
            remain_d = remain_q - 1'b1;
            offA_d   = lastA ? '0 : offA_q + 1'b1;
            offB_d   = lastB ? '0 : offB_q + 1'b1;
            if (lastA) begin
                addrA_d  = addrA_q + 1'b1;
                aValid_d = 1'b0;
            end
            if (lastB && !isMove) begin
                addrB_d  = addrB_q + 1'b1;
                bValid_d = 1'b0;
            end
        end

        // Unequal pair ends a compare with the signed count
        if (decide) begin
            result_d = greater ? countWord : ~countWord; // RULE14 RULE16
            done_d   = 1'b1;
            state_d  = S_IDLE;
        end

        // Start a field pair from the decoded fields
        if (loadNow && badOff) begin
            oor_d   = 1'b1; // RULE4
            done_d  = 1'b1;
            state_d = S_IDLE;
        end else if (loadNow && fLen == '0) begin
            done_d  = 1'b1; // RULE9
            state_d = S_IDLE;
        end else if (loadNow) begin
            addrA_d  = fSa; // RULE3
            offA_d   = fSo;
            addrB_d  = fDa;
            offB_d   = fDo;
            remain_d = fLen;
            aValid_d = 1'b0;
            bValid_d = 1'b0;
            dirty_d  = 1'b0;
            stop_d   = 1'b0;
            state_d  = S_STEP;
        end

        // Reference past field length aborts midway
        if (mem.oor) begin
            oor_d   = 1'b1; // RULE5
            done_d  = 1'b1;
            dirty_d = 1'b0;
            state_d = S_IDLE;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q  <= S_IDLE;
            op_q     <= cfm_pkg::OP_MOVE_DIR;
            addrA_q  <= '0;
            addrB_q  <= '0;
            offA_q   <= '0;
            offB_q   <= '0;
            remain_q <= '0;
            wordA_q  <= '0;
            wordB_q  <= '0;
            aValid_q <= 1'b0;
            bValid_q <= 1'b0;
            dirty_q  <= 1'b0;
            stop_q   <= 1'b0;
            colA_q   <= '0;
            result_q <= cfm_pkg::RESULT_RST;
            done_q   <= 1'b0;
            oor_q    <= 1'b0;
            ill_q    <= 1'b0;
            intr_q   <= 1'b0;
            skip_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            op_q     <= op_d;
            addrA_q  <= addrA_d;
            addrB_q  <= addrB_d;
            offA_q   <= offA_d;
            offB_q   <= offB_d;
            remain_q <= remain_d;
            wordA_q  <= wordA_d;
            wordB_q  <= wordB_d;
            aValid_q <= aValid_d;
            bValid_q <= bValid_d;
            dirty_q  <= dirty_d;
            stop_q   <= stop_d;
            colA_q   <= colA_d;
            result_q <= result_d;
            done_q   <= done_d;
            oor_q    <= oor_d;
            ill_q    <= ill_d;
            intr_q   <= intr_d;
            skip_q   <= skip_d;
        end
    end

    // Status pulses come from registers and rise on the deciding edge
    assign busy             = (state_q != S_IDLE);
    assign done             = done_q;
    assign outOfRange       = oor_q;
    assign illegalInstr     = ill_q;
    assign interrupted      = intr_q;
    assign skipLowerParcels = skip_q;
    assign compareResultReg = result_q;
endmodule

// ===== design/cfm_pkg.sv
// How it works
// RULE1: Accept operations only from parcel zero.
// RULE2: Ten 6-bit characters per word, any boundary.
// RULE3: Fields start at word address plus offset.
// RULE4: Offset above nine is out of range.
// RULE5: Reference past field length flags out of range.
// RULE6: Length joins low four and high nine bits.
// RULE7: Direct move and compares: seven-bit length, 127.
// RULE8: Indirect move allows up to 8191 characters.
// RULE9: Zero length makes the operation a pass.
// RULE10: Overlapping moves need source above result.
// RULE11: Exchange interrupts while remaining length exceeds 0377.
// RULE12: Indirect descriptor fetched from index plus constant.
// RULE13: Indirect move clears result, skips lower parcels.
// RULE14: Result zero, count, or complemented count.
// RULE15: Collated compare looks up unequal pairs.
// RULE16: Count is pairs not yet compared plus one.
// RULE17: Collating table: eight words from table base.
// RULE18: High bits pick word, low bits pick character.
// RULE19: Uncollated compare uses raw character codes.
// RULE20: Position zero is the most significant character.
package cfm_pkg;
    localparam int WORD_W  = 60;
    localparam int CHAR_W  = 6;
    localparam int CHARS   = 10;
    localparam int ADDR_W  = 18;
    localparam int LEN_W   = 13;
    localparam int POS_W   = 4;
    localparam int LO_W    = 4;
    localparam int HI_W    = 9;
    localparam int HI_DIR_W = 3;

    // Field positions, word and descriptor
    localparam int DA_POS  = 0;
    localparam int DO_POS  = 18;
    localparam int SA_POS  = 22;
    localparam int SO_POS  = 40;
    localparam int LO_POS  = 44;
    localparam int HI_POS  = 48;
    localparam int KJ_POS  = 30;

    localparam logic [POS_W-1:0]  LAST_POS    = 4'h9;
    localparam logic [LEN_W-1:0]  INTR_LIMIT  = 13'h00FF;
    localparam logic [WORD_W-1:0] RESULT_RST  = 60'h000000000000000;
    localparam logic [1:0]        FIRST_PARCEL = 2'h0;

    typedef enum logic [1:0] {
        OP_MOVE_IND,
        OP_MOVE_DIR,
        OP_CMP_COL,
        OP_CMP_UNC
    } cfm_op_t;
endpackage

// ===== design/cfm_mem_if.sv
// Request path from the sequencer to the memory port
interface cfm_mem_if;
    logic                        req;
    logic                        we;
    logic [cfm_pkg::ADDR_W-1:0]  addr;
    logic [cfm_pkg::WORD_W-1:0]  wdata;
    logic                        ack;
    logic                        oor;
    logic [cfm_pkg::WORD_W-1:0]  rdata;

    modport unit (output req, output we, output addr, output wdata,
                  input ack, input oor, input rdata);
    modport port (input req, input we, input addr, input wdata,
                  output ack, output oor, output rdata);
endinterface

// ===== design/cfm_char_lane.sv
// Picks one character out of a word and merges one into it
module cfm_char_lane #(
    parameter int CHARS  = 10,
    parameter int CHAR_W = 6
) (
    input  wire logic [CHARS*CHAR_W-1:0] word,
    input  wire logic [3:0]              pos,
    input  wire logic [CHAR_W-1:0]       newChar,
    output logic      [CHAR_W-1:0]       chr,
    output logic      [CHARS*CHAR_W-1:0] merged
);
    logic [CHAR_W-1:0] orChain [CHARS+1];

    assign orChain[0] = '0;

    // Position zero sits in the top six bits
    for (genvar i = 0; i < CHARS; i++) begin : g_pos
        localparam int LSB = (CHARS - 1 - i) * CHAR_W; // RULE20
        wire sel = (pos == 4'(i)); // RULE2
        assign merged[LSB +: CHAR_W] = sel ? newChar : word[LSB +: CHAR_W];
        assign orChain[i+1] = orChain[i] | (sel ? word[LSB +: CHAR_W] : '0);
    end

    assign chr = orChain[CHARS];
endmodule

// ===== design/cfm_mem_port.sv
// Holds one memory reference at a time and checks it against the field length
module cfm_mem_port (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [cfm_pkg::ADDR_W-1:0]  relBase,
    input  wire logic [cfm_pkg::ADDR_W-1:0]  fieldLength,
    cfm_mem_if.port                          cmd,
    output logic                             memReq,
    output logic                             memWrite,
    output logic      [cfm_pkg::ADDR_W-1:0]  memAddr,
    output logic      [cfm_pkg::WORD_W-1:0]  memWdata,
    input  wire logic                        memAck,
    input  wire logic [cfm_pkg::WORD_W-1:0]  memRdata
);
    logic busy_q;

    // Relative address must lie below the field length
    wire inRange = cmd.addr < fieldLength; // RULE5
    wire accept  = cmd.req && !busy_q;

    // Out of range is answered at once, nothing reaches memory
    assign cmd.oor   = accept && !inRange; // RULE5
    assign cmd.ack   = busy_q && memAck;
    assign cmd.rdata = memRdata;
    assign memReq    = busy_q;

    // Address and data are held steady for the whole reference
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_q   <= 1'b0;
            memWrite <= 1'b0;
            memAddr  <= '0;
            memWdata <= '0;
        end else if (accept && inRange) begin
            busy_q   <= 1'b1;
            memWrite <= cmd.we;
            memAddr  <= relBase + cmd.addr;
            memWdata <= cmd.wdata;
        end else if (memAck) begin
            busy_q   <= 1'b0;
        end
    end
endmodule

// ===== bench/cfm_unit_monitor.sv
// Watches the command and memory ports of the sequencer
module cfm_unit_monitor (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        issue,
    input wire logic [1:0]  opcode,
    input wire logic [1:0]  parcel,
    input wire logic [59:0] instrWord,
    input wire logic [17:0] programRelativeBase,
    input wire logic [17:0] programFieldLength,
    input wire logic        memReq,
    input wire logic        memWrite,
    input wire logic [17:0] memAddr,
    input wire logic [59:0] memWdata,
    input wire logic        memAck,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        illegalInstr,
    input wire logic        outOfRange,
    input wire logic        interrupted,
    input wire logic        skipLowerParcels,
    input wire logic [59:0] compareResultReg
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Decode of a taken command
    wire       taken  = issue && !busy;
    wire [6:0] lenDir = {instrWord[50:48], instrWord[47:44]};
    wire       offBad = instrWord[43:40] > 4'h9 || instrWord[21:18] > 4'h9;
    sequence dirTake;
        taken && parcel == 2'h0 && opcode != cfm_pkg::OP_MOVE_IND;
    endsequence
    sequence quickEnd;
        done && !busy && !memReq;
    endsequence
    illegal_parcel_a:
        assert property (taken && parcel != 2'h0 |=> illegalInstr && !done && !memReq)
        else $error("parcel not refused");
    bad_offset_a:
        assert property (dirTake ##0 (lenDir != 7'h00 && offBad) |=> quickEnd ##0 outOfRange)
        else $error("bad offset not reported");
    zero_pass_a:
        assert property (dirTake ##0 (lenDir == 7'h00 && !offBad) |=> quickEnd ##0 !outOfRange)
        else $error("zero length not a pass");
    req_hold_a:
        assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite) && $stable(memWdata))
        else $error("request changed early");
    ref_gap_a:
        assert property (memAck |=> !memReq)
        else $error("no gap after reference");
    addr_range_a:
        assert property (memReq |-> 18'(memAddr - programRelativeBase) < programFieldLength)
        else $error("reference out of range");
    oor_done_a:
        assert property (outOfRange |-> done && !busy)
        else $error("out of range without done");
    skip_clear_a:
        assert property (skipLowerParcels |-> done && compareResultReg == 60'h000000000000000)
        else $error("result not cleared");
    int_done_a:
        assert property (interrupted |-> done && !skipLowerParcels && !outOfRange)
        else $error("stray interrupt flag");
endmodule

bind cfm_unit cfm_unit_monitor i_mon (.*);

// ===== bench/cfm_mem_model.sv
// Central memory behind the memory port, prompt or slow
module cfm_mem_model (
    input wire logic        clk,
    input wire logic        slow,
    input wire logic        memReq,
    input wire logic        memWrite,
    input wire logic [17:0] memAddr,
    input wire logic [59:0] memWdata,
    output logic            memAck,
    output logic     [59:0] memRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [59:0] mem [0:1023];
    int          waitQ;
    // Distinct filler per word
    initial begin
        memAck = 1'b0;
        memRdata = 60'h000000000000000;
        for (int i = 0; i < 1024; i++) mem[i] = {6{i[9:0]}};
    end
    // Read data inverts unless a read is answered
    always @(posedge clk) begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
        if (memReq && !memAck) begin
            if (waitQ < (slow ? 3 : 0)) waitQ <= waitQ + 1;
            else begin
                waitQ <= 0;
                memAck <= 1'b1;
                if (memWrite) mem[memAddr[9:0]] <= memWdata;
                else memRdata <= mem[memAddr[9:0]];
            end
        end
    end
endmodule

// ===== bench/tb_cfm_unit.sv
module tb_cfm_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk, reset, issue, exchangeReq, slow, memReq, memWrite, memAck;
    logic             busy, done, illegalInstr, outOfRange, interrupted, skipLowerParcels;
    cfm_pkg::cfm_op_t opcode;
    logic [1:0]       parcel;
    logic [59:0]      instrWord, memRdata, memWdata, compareResultReg;
    logic [17:0]      indexRegJ, collateTableBaseReg, programRelativeBase, programFieldLength, memAddr;
    logic [4:0]       fl;
    int               fails, compares;

    cfm_unit i_dut (.*);
    cfm_mem_model i_mem (.*);

    // Clock
    always #10 clk = ~clk;

    // Comparisons
    task automatic chk(logic [59:0] g, e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkf(logic [4:0] g, e);
        chk(60'(g), 60'(e));
    endtask

    // Character addressing in memory: position zero is the top six bits
    function automatic int wa(int k, int c, int i);
        return k + (c + i) / 10;
    endfunction
    function automatic int sh(int c, int i);
        return 59 - 6 * ((c + i) % 10);
    endfunction
    task automatic putc(int k, int c, int i, logic [5:0] v);
        i_mem.mem[wa(k, c, i)][sh(c, i) -: 6] = v;
    endtask
    function automatic logic [5:0] getc(int k, int c, int i);
        return i_mem.mem[wa(k, c, i)][sh(c, i) -: 6];
    endfunction
    function automatic logic [59:0] mk(int sw, int so, int dw, int dc, int n);
        return {3'h0, 13'(n), 4'(so), 18'(sw), 4'(dc), 18'(dw)};
    endfunction

    // One command; flags caught while they stand
    task automatic run(cfm_pkg::cfm_op_t op, logic [1:0] pc, logic [59:0] iw);
        @(posedge clk) #1;
        issue = 1'b1;
        opcode = op;
        parcel = pc;
        instrWord = iw;
        @(posedge clk) #1;
        issue = 1'b0;
        for (int n = 0; done !== 1'b1 && illegalInstr !== 1'b1 && n < 20000; n++) @(posedge clk) #1;
        fl = {done, illegalInstr, outOfRange, interrupted, skipLowerParcels};
    endtask

    // Move; data judged only on a clean end
    task automatic move(cfm_pkg::cfm_op_t op, int sw, int so, int dw, int dc, int n, logic [4:0] ef);
        logic [59:0] e [0:1023];
        logic [59:0] iw;
        e = i_mem.mem;
        for (int i = 0; i < n; i++) e[wa(dw, dc, i)][sh(dc, i) -: 6] = getc(sw, so, i);
        iw = mk(sw, so, dw, dc, n);
        if (op == cfm_pkg::OP_MOVE_IND) begin
            i_mem.mem[20] = iw;
            iw = {12'h000, 18'h00008, 30'h00000000};
        end
        run(op, 2'h0, iw);
        chkf(fl, ef);
        if (ef[2:1] == 2'b00) for (int a = dw - 1; a <= wa(dw, dc, n) + 1; a++) chk(i_mem.mem[a], e[a]);
    endtask

    // Field one at 200 offset 3, field two at 300 offset 8
    task automatic cmp(cfm_pkg::cfm_op_t op, int n, logic [59:0] er);
        run(op, 2'h0, mk(200, 3, 300, 8, n));
        chkf(fl, 5'b10000);
        chk(compareResultReg, er);
    endtask

    task automatic t_illegal();
        for (int p = 1; p < 4; p++) begin
            run(cfm_pkg::cfm_op_t'(p), 2'(p), mk(100, 0, 40, 0, 5));
            chkf(fl, 5'b01000);
        end
    endtask
    task automatic t_move_dir();
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            move(cfm_pkg::OP_MOVE_DIR, 100, 7, 40, 2 + 7 * s, 23 + 104 * s, 5'b10000);
        end
        slow = 1'b0;
    endtask
    task automatic t_cmp_unc();
        for (int i = 0; i < 20; i++) putc(300, 8, i, getc(200, 3, i));
        cmp(cfm_pkg::OP_CMP_UNC, 20, 60'h000000000000000);
        putc(200, 3, 12, 6'h30);
        putc(300, 8, 12, 6'h20);
        cmp(cfm_pkg::OP_CMP_UNC, 20, 60'h000000000000008);
        putc(200, 3, 12, 6'h20);
        putc(300, 8, 12, 6'h30);
        cmp(cfm_pkg::OP_CMP_UNC, 20, ~60'h000000000000008);
    endtask
    // Table at 500 is identity except that hex 11 collates as hex 10
    task automatic t_cmp_col();
        for (int i = 0; i < 80; i++) putc(500, 0, i, (i % 10 < 8) ? 6'((i / 10) * 8 + i % 10) : 6'h00);
        putc(500, 0, 21, 6'h10);
        for (int i = 0; i < 15; i++) putc(300, 8, i, getc(200, 3, i));
        putc(200, 3, 4, 6'h10);
        putc(300, 8, 4, 6'h11);
        cmp(cfm_pkg::OP_CMP_COL, 15, 60'h000000000000000);
        cmp(cfm_pkg::OP_CMP_UNC, 15, ~60'h00000000000000B);
        putc(200, 3, 9, 6'h05);
        putc(300, 8, 9, 6'h07);
        cmp(cfm_pkg::OP_CMP_COL, 15, ~60'h000000000000006);
        cmp(cfm_pkg::OP_CMP_UNC, 0, ~60'h000000000000006);
    endtask
    task automatic t_move_ind();
        move(cfm_pkg::OP_MOVE_IND, 100, 5, 40, 0, 130, 5'b10001);
        chk(compareResultReg, 60'h000000000000000);
    endtask
    task automatic t_faults();
        move(cfm_pkg::OP_MOVE_DIR, 100, 10, 40, 0, 5, 5'b10100);
        move(cfm_pkg::OP_MOVE_DIR, 100, 0, 40, 15, 5, 5'b10100);
        move(cfm_pkg::OP_MOVE_DIR, 1017, 0, 40, 0, 70, 5'b10100);
    endtask
    // Exchange held high: short fields finish, long ones stop
    task automatic t_exchange();
        exchangeReq = 1'b1;
        cmp(cfm_pkg::OP_CMP_COL, 15, ~60'h000000000000006);
        move(cfm_pkg::OP_MOVE_IND, 100, 0, 40, 0, 300, 5'b10010);
        exchangeReq = 1'b0;
    endtask

    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the expected run length
    initial begin
        #1500000;
        fails++;
        complete_run();
    end

    // Main sequence
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        issue = 1'b0;
        opcode = cfm_pkg::OP_MOVE_DIR;
        parcel = 2'h0;
        instrWord = 60'h000000000000000;
        indexRegJ = 18'h0000C;
        collateTableBaseReg = 18'h001F4;
        programRelativeBase = 18'h00000;
        programFieldLength = 18'h003FF;
        exchangeReq = 1'b0;
        slow = 1'b0;
        fails = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        #1;
        reset = 1'b0;
        t_illegal();
        t_move_dir();
        t_cmp_unc();
        t_cmp_col();
        t_move_ind();
        t_faults();
        t_exchange();
        complete_run();
    end
endmodule
